// File: hdl/pefl_pkg.sv
// package for the protection element flag logic
package pefl_pkg;
	localparam int MEAS_W      = 16;
	localparam int DLY_W       = 16;
	localparam int GROUP_CNT   = 8;
	localparam int GROUP_W     = 3;
	localparam int PWD_MAX     = 10;
	localparam int PWD_IDX_W   = 4;
	localparam int DIGIT_W     = 4;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
	localparam logic [PWD_IDX_W-1:0] IDX_ZERO = 4'h0;
	localparam logic [PWD_IDX_W-1:0] IDX_ONE  = 4'h1;

	typedef enum logic [1:0] {TGT_DISABLED, TGT_SELF_RESET, TGT_LATCHED} pefl_target_e;

	typedef struct packed {
		logic [MEAS_W-1:0] pickupLevel;
		logic [DLY_W-1:0]  pickupDelay;
		logic [DLY_W-1:0]  resetDelay;
	} pefl_setting_s;

	typedef struct packed {
		logic pickupEvent;
		logic dropoutEvent;
		logic operateEvent;
	} pefl_events_s;

	typedef struct packed {
		logic             valid;
		logic             isEnter;
		logic [DIGIT_W-1:0] digit;
	} pefl_key_s;
endpackage

// File: hdl/pefl_element.sv
// protection element: comparator, timers, target, events, groups, password entry
`timescale 1ns/1ps
module pefl_element #(
	parameter int MEAS_W  = pefl_pkg::MEAS_W,
	parameter int DLY_W   = pefl_pkg::DLY_W,
	parameter int GROUPS  = pefl_pkg::GROUP_CNT,
	parameter int PWD_LEN = pefl_pkg::PWD_MAX
) (
	input  wire logic                         clk_sys,         // 200 MHz system clock
	input  wire logic                         sys_rst,         // async reset, active high
	input  wire logic                         functionEnable,  // function setting enabled
	input  wire logic                         overMode,        // 1 over threshold, 0 under
	input  wire logic [MEAS_W-1:0]            measured,        // measured quantity
	input  wire logic                         blockIn,         // block input
	input  wire logic                         runIn,           // supervisory run input
	input  wire logic                         group_dependent_class, // 1 group_dependent_class, 0 control
	input  wire logic [2:0]                   activeGroup,     // active group 0..7 = groups 1..8
	input  wire pefl_pkg::pefl_setting_s      groupSet [GROUPS], // group_dependent_class setting sets
	input  wire pefl_pkg::pefl_setting_s      controlSet,      // control-class setting set
	input  wire pefl_pkg::pefl_target_e       targetMode,      // target mode
	input  wire logic                         eventsEnable,    // event recording enable
	input  wire logic                         resetCmd,        // reset command pulse
	input  wire pefl_pkg::pefl_key_s          key,             // keypad input
	input  wire logic                         pwdChangeReq,    // start password change
	output logic                              pickupFlag,      // pickup flag
	output logic                              operateFlag,     // operate flag
	output logic                              targetOn,        // target message and LED
	output pefl_pkg::pefl_events_s            events,          // event pulses
	output logic                              pwdStored,       // new password stored, pulse
	output logic                              pwdRejected,     // entry refused, pulse
	output logic [PWD_LEN*4-1:0]              activePwd,       // active password digits
	output logic [3:0]                        activePwdLen     // active password length
);
	typedef enum {PW_IDLE, PW_OLD, PW_NEW, PW_VERIFY} pefl_pw_e;

	pefl_pkg::pefl_setting_s set;
	logic                    runOk, beyond;
	logic                    pickR, pickNxt, opR, opNxt, tgtR, tgtNxt;
	logic [DLY_W-1:0]        cntR, cntNxt;
	pefl_pkg::pefl_events_s  evR, evNxt;

	assign runOk = functionEnable && runIn && !blockIn;
	always_comb
	begin
		set = group_dependent_class ? groupSet[activeGroup] : controlSet;
		beyond = overMode ? (measured > set.pickupLevel) : (measured < set.pickupLevel);
	end

	always_comb
	begin
		pickNxt = runOk && beyond;
		opNxt   = opR;
		cntNxt  = cntR;
		if (!runOk)
		begin
			opNxt  = 1'b0;
			cntNxt = pefl_pkg::DLY_ZERO;
		end
		else if (!opR)
		begin
			if (!beyond)
				cntNxt = pefl_pkg::DLY_ZERO;
			else if (cntR >= set.pickupDelay)
			begin
				opNxt  = 1'b1;
				cntNxt = pefl_pkg::DLY_ZERO;
			end
			else
				cntNxt = DLY_W'(cntR + 1'b1);
		end
		else
		begin
			if (beyond)
				cntNxt = pefl_pkg::DLY_ZERO;
			else if (cntR >= set.resetDelay)
			begin
				opNxt  = 1'b0;
				cntNxt = pefl_pkg::DLY_ZERO;
			end
			else
				cntNxt = DLY_W'(cntR + 1'b1);
		end
		case (targetMode)
			pefl_pkg::TGT_SELF_RESET: tgtNxt = opNxt;
			pefl_pkg::TGT_LATCHED:    tgtNxt = opNxt || (tgtR && !resetCmd);
			default:                  tgtNxt = 1'b0;
		endcase
		evNxt.pickupEvent  = eventsEnable && pickNxt && !pickR;
		evNxt.dropoutEvent = eventsEnable && !pickNxt && pickR;
		evNxt.operateEvent = eventsEnable && opNxt && !opR;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pickR <= 1'b0;
			opR   <= 1'b0;
			tgtR  <= 1'b0;
			cntR  <= pefl_pkg::DLY_ZERO;
			evR   <= '0;
		end
		else
		begin
			pickR <= pickNxt;
			opR   <= opNxt;
			tgtR  <= tgtNxt;
			cntR  <= cntNxt;
			evR   <= evNxt;
		end
	end

	assign pickupFlag  = pickR;
	assign operateFlag = opR;
	assign targetOn    = tgtR;
	assign events      = evR;

	// password change: old check (skipped while no password is set), new entry, verify, then store
	pefl_pw_e                pwR, pwNxt;
	logic [PWD_LEN*4-1:0]    bufR, bufNxt, newR, newNxt, actR, actNxt;
	logic [3:0]              lenR, lenNxt, nLenR, nLenNxt, aLenR, aLenNxt;
	logic                    badR, badNxt, stR, stNxt, rjR, rjNxt;
	logic                    isDigit;

	assign isDigit = !key.isEnter && (key.digit <= pefl_pkg::DIGIT_MAX);
	always_comb
	begin
		pwNxt = pwR; bufNxt = bufR; newNxt = newR; actNxt = actR;
		lenNxt = lenR; nLenNxt = nLenR; aLenNxt = aLenR; badNxt = badR;
		stNxt = 1'b0; rjNxt = 1'b0;
		case (pwR)
			PW_IDLE:
			begin
				if (pwdChangeReq)
				begin
					pwNxt = (aLenR == pefl_pkg::IDX_ZERO) ? PW_NEW : PW_OLD;
					bufNxt = '0; lenNxt = pefl_pkg::IDX_ZERO; badNxt = 1'b0;
				end
			end
			default:
			begin
				if (key.valid && !key.isEnter)
				begin
					if (!isDigit || lenR >= 4'(PWD_LEN))
						badNxt = 1'b1;
					else
					begin
						bufNxt = {bufR[PWD_LEN*4-5:0], key.digit};
						lenNxt = 4'(lenR + pefl_pkg::IDX_ONE);
					end
				end
				else if (key.valid)
				begin
					bufNxt = '0; lenNxt = pefl_pkg::IDX_ZERO; badNxt = 1'b0;
					if (badR || lenR == pefl_pkg::IDX_ZERO)
					begin
						rjNxt = 1'b1; pwNxt = PW_IDLE;
					end
					else if (pwR == PW_OLD)
					begin
						if (bufR == actR && lenR == aLenR)
							pwNxt = PW_NEW;
						else
						begin
							rjNxt = 1'b1; pwNxt = PW_IDLE;
						end
					end
					else if (pwR == PW_NEW)
					begin
						newNxt = bufR; nLenNxt = lenR; pwNxt = PW_VERIFY;
					end
					else
					begin
						pwNxt = PW_IDLE;
						if (bufR == newR && lenR == nLenR)
						begin
							actNxt = newR; aLenNxt = nLenR; stNxt = 1'b1;
						end
						else
							rjNxt = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pwR <= PW_IDLE; bufR <= '0; newR <= '0; actR <= '0;
			lenR <= '0; nLenR <= '0; aLenR <= '0; badR <= 1'b0; stR <= 1'b0; rjR <= 1'b0;
		end
		else
		begin
			pwR <= pwNxt; bufR <= bufNxt; newR <= newNxt; actR <= actNxt;
			lenR <= lenNxt; nLenR <= nLenNxt; aLenR <= aLenNxt; badR <= badNxt; stR <= stNxt; rjR <= rjNxt;
		end
	end

	assign pwdStored    = stR;
	assign pwdRejected  = rjR;
	assign activePwd    = actR;
	assign activePwdLen = aLenR;

	property p_run_clear;
		@(posedge clk_sys) disable iff (sys_rst) !runOk |=> !pickR && !opR;
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("run clear failed");
	property p_block;
		@(posedge clk_sys) disable iff (sys_rst) blockIn |=> !pickR;
	endproperty
	a_block: assert property (p_block) else $error("block ignored");
	// pickup registers on the same edge as operate, so a zero delay still passes
	property p_op_needs_pick;
		@(posedge clk_sys) disable iff (sys_rst) $rose(opR) |-> pickR;
	endproperty
	a_op_needs_pick: assert property (p_op_needs_pick) else $error("operate without pickup");
	property p_tgt_off;
		@(posedge clk_sys) disable iff (sys_rst) targetMode == pefl_pkg::TGT_DISABLED |=> !tgtR;
	endproperty
	a_tgt_off: assert property (p_tgt_off) else $error("target while disabled");
	property p_latch;
		@(posedge clk_sys) disable iff (sys_rst)
			targetMode == pefl_pkg::TGT_LATCHED && tgtR && !resetCmd |=> tgtR;
	endproperty
	a_latch: assert property (p_latch) else $error("latched target lost");
	property p_dpo;
		@(posedge clk_sys) disable iff (sys_rst) $past(eventsEnable) && $fell(pickR) |-> evR.dropoutEvent;
	endproperty
	a_dpo: assert property (p_dpo) else $error("dropout event missing");
	property p_no_ev;
		@(posedge clk_sys) disable iff (sys_rst) !$past(eventsEnable) |-> evR == '0;
	endproperty
	a_no_ev: assert property (p_no_ev) else $error("event while disabled");
	property p_pulse;
		@(posedge clk_sys) disable iff (sys_rst) evR.operateEvent |=> !evR.operateEvent;
	endproperty
	a_pulse: assert property (p_pulse) else $error("operate event not a pulse");
	property p_fn_off;
		@(posedge clk_sys) disable iff (sys_rst) !functionEnable |=> !pickR && !opR;
	endproperty
	a_fn_off: assert property (p_fn_off) else $error("element active while disabled");
	property p_pick;
		@(posedge clk_sys) disable iff (sys_rst) runOk && beyond |=> pickR;
	endproperty
	a_pick: assert property (p_pick) else $error("pickup flag missing");
	property p_self_tgt;
		@(posedge clk_sys) disable iff (sys_rst) targetMode == pefl_pkg::TGT_SELF_RESET |=> tgtR == opR;
	endproperty
	a_self_tgt: assert property (p_self_tgt) else $error("self-reset target off operate");
	// enable taken from the previous edge, where the event was decided
	property p_pick_ev;
		@(posedge clk_sys) disable iff (sys_rst) $past(eventsEnable) && $rose(pickR) |-> evR.pickupEvent;
	endproperty
	a_pick_ev: assert property (p_pick_ev) else $error("pickup event missing");
	property p_op_ev;
		@(posedge clk_sys) disable iff (sys_rst) $past(eventsEnable) && $rose(opR) |-> evR.operateEvent;
	endproperty
	a_op_ev: assert property (p_op_ev) else $error("operate event missing");
	sequence s_verify_enter;
		pwR == PW_VERIFY && key.valid && key.isEnter;
	endsequence
	sequence s_entries_match;
		!badR && lenR != pefl_pkg::IDX_ZERO && bufR == newR && lenR == nLenR;
	endsequence
	sequence s_old_wrong;
		pwR == PW_OLD && key.valid && key.isEnter && (bufR != actR || lenR != aLenR);
	endsequence
	property p_store;
		@(posedge clk_sys) disable iff (sys_rst)
			s_verify_enter ##0 s_entries_match |=> stR && actR == $past(newR);
	endproperty
	a_store: assert property (p_store) else $error("verified password not stored");
	property p_store_only;
		@(posedge clk_sys) disable iff (sys_rst) $changed(actR) |-> stR;
	endproperty
	a_store_only: assert property (p_store_only) else $error("password changed without store");
	property p_old_check;
		@(posedge clk_sys) disable iff (sys_rst) s_old_wrong |=> rjR && pwR == PW_IDLE;
	endproperty
	a_old_check: assert property (p_old_check) else $error("wrong old password accepted");
endmodule

// File: verif/pefl_element_tb_top.sv
// self-checking bench for the protection element flag logic
`timescale 1ns/1ps
module pefl_element_tb_top;
	logic                    clk_sys = 0;
	logic                    sys_rst = 1;
	logic                    fnEn = 0, overMode = 1, blockIn = 0, runIn = 0;
	logic                    grp = 1, evEn = 1, resetCmd = 0, pwdReq = 0;
	logic [15:0]             measured = 16'h0000;
	logic [2:0]              actGrp = 3'h2;
	pefl_pkg::pefl_setting_s gs [8];
	pefl_pkg::pefl_setting_s cs;
	pefl_pkg::pefl_target_e  tMode = pefl_pkg::TGT_SELF_RESET;
	pefl_pkg::pefl_key_s     key = '0;
	pefl_pkg::pefl_events_s  ev;
	logic                    pickupFlag, operateFlag, targetOn, pwdStored, pwdRejected;
	logic [39:0]             activePwd;
	logic [3:0]              activePwdLen;
	int                      error_cnt = 0, n_checks = 0, nSt = 0, nRj = 0;
	localparam int           PD = 3, RD = 2;

	always #2.5 clk_sys = ~clk_sys;
	// pulses counted here, so a refusal mid-entry is never missed
	always @(negedge clk_sys)
	begin
		if (pwdStored === 1'b1) nSt++;
		if (pwdRejected === 1'b1) nRj++;
	end

	pefl_element DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .functionEnable(fnEn), .overMode(overMode),
		.measured(measured), .blockIn(blockIn), .runIn(runIn), .group_dependent_class(grp),
		.activeGroup(actGrp), .groupSet(gs), .controlSet(cs), .targetMode(tMode), .eventsEnable(evEn),
		.resetCmd(resetCmd), .key(key), .pwdChangeReq(pwdReq), .pickupFlag(pickupFlag),
		.operateFlag(operateFlag), .targetOn(targetOn), .events(ev), .pwdStored(pwdStored),
		.pwdRejected(pwdRejected), .activePwd(activePwd), .activePwdLen(activePwdLen));

	task automatic stp(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic chk(input string n, input logic [39:0] g, input logic [39:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cycle_elem(input logic e, input pefl_pkg::pefl_target_e m);
		evEn = e;
		tMode = m;
		measured = 16'h0200;
		stp(1);
		chk("pickup", pickupFlag, 1'b1);
		chk("pkpEvent", ev.pickupEvent, e);
		stp(1);
		chk("pkpPulse", ev.pickupEvent, 1'b0);
		stp(PD - 2);
		chk("opEarly", operateFlag, 1'b0);
		stp(1);
		chk("opOn", operateFlag, 1'b1);
		chk("opEvent", ev.operateEvent, e);
		chk("tgtOn", targetOn, m != pefl_pkg::TGT_DISABLED);
		measured = 16'h0000;
		stp(1);
		chk("drop", pickupFlag, 1'b0);
		chk("dpoEvent", ev.dropoutEvent, e);
		chk("opHeld", operateFlag, 1'b1);
		stp(RD - 1);
		chk("opHold", operateFlag, 1'b1);
		stp(1);
		chk("opOff", operateFlag, 1'b0);
		chk("tgtAfter", targetOn, m == pefl_pkg::TGT_LATCHED);
		stp(3);
		chk("tgtStays", targetOn, m == pefl_pkg::TGT_LATCHED);
		resetCmd = 1;
		stp(1);
		resetCmd = 0;
		stp(2);
		chk("tgtCleared", targetOn, 1'b0);
	endtask

	task automatic gate_test;
		for (int i = 0; i < 3; i++)
		begin
			measured = 16'h0200;
			stp(PD + 3);
			chk("opBefore", operateFlag, 1'b1);
			runIn = (i != 0);
			blockIn = (i == 1);
			fnEn = (i != 2);
			stp(1);
			chk("pkpGated", pickupFlag, 1'b0);
			chk("opGated", operateFlag, 1'b0);
			runIn = 1;
			blockIn = 0;
			fnEn = 1;
			stp(PD);
			chk("timerCleared", operateFlag, 1'b0);
			stp(1);
			chk("opRestart", operateFlag, 1'b1);
			measured = 16'h0000;
			stp(RD + 6);
		end
	endtask

	task automatic group_test;
		logic [15:0] lvl;
		for (int g = 0; g < 9; g++)
		begin
			grp = (g < 8);
			actGrp = 3'(g);
			lvl = (g < 8) ? gs[g].pickupLevel : cs.pickupLevel;
			measured = lvl;
			stp(2);
			chk("atLevel", pickupFlag, 1'b0);
			measured = lvl + 16'h0001;
			stp(2);
			chk("aboveLevel", pickupFlag, 1'b1);
			measured = 16'h0000;
			stp(RD + 6);
		end
		grp = 1;
		actGrp = 3'h2;
		measured = 16'h0120;
		overMode = 0;
		stp(2);
		chk("underAt", pickupFlag, 1'b0);
		measured = 16'h011f;
		stp(2);
		chk("underBelow", pickupFlag, 1'b1);
		measured = 16'h0120;
		stp(RD + 6);
		overMode = 1;
		measured = 16'h0000;
	endtask

	// '#' stands for the enter key, ':' for a digit above nine
	task automatic pwd(input string s, input logic ok, input logic [39:0] p, input logic [3:0] n);
		pwdReq = 1;
		stp(1);
		pwdReq = 0;
		for (int i = 0; i < s.len(); i++)
		begin
			key = '{1'b1, s[i] == "#", 4'(s[i] - 8'h30)};
			stp(1);
		end
		key = '0;
		stp(4);
		chk("stored", 40'(nSt), 40'(ok));
		chk("rejected", 40'(nRj), 40'(!ok));
		chk("activePwd", activePwd, p);
		chk("pwdLen", activePwdLen, n);
		nSt = 0;
		nRj = 0;
	endtask

	initial
	begin
		for (int i = 0; i < 8; i++) gs[i] = '{16'h0100 + 16'(i * 16), 16'(PD), 16'(RD)};
		cs = '{16'h0300, 16'(PD), 16'(RD)};
		stp(12);
		sys_rst = 0;
		chk("rstOut", {pickupFlag, operateFlag, targetOn, ev, pwdStored, pwdRejected, activePwdLen}, 40'h0);
		fnEn = 1;
		measured = 16'h0200;
		stp(4);
		chk("noRun", pickupFlag, 1'b0);
		fnEn = 0;
		runIn = 1;
		stp(4);
		chk("fnOff", pickupFlag, 1'b0);
		fnEn = 1;
		measured = 16'h0000;
		stp(4);
		cycle_elem(1'b1, pefl_pkg::TGT_SELF_RESET);
		cycle_elem(1'b0, pefl_pkg::TGT_DISABLED);
		cycle_elem(1'b1, pefl_pkg::TGT_LATCHED);
		measured = 16'h0200;
		stp(2);
		measured = 16'h0000;
		for (int i = 0; i < 6; i++)
		begin
			stp(1);
			chk("shortPkp", operateFlag, 1'b0);
		end
		gate_test();
		group_test();
		pwd("12#12#", 1'b1, 40'h12, 4'h2);
		pwd("12#345#346#", 1'b0, 40'h12, 4'h2);
		pwd("99#", 1'b0, 40'h12, 4'h2);
		pwd("12#:#", 1'b0, 40'h12, 4'h2);
		pwd("12#01234567890#", 1'b0, 40'h12, 4'h2);
		pwd("12#0123456789#0123456789#", 1'b1, 40'h0123456789, 4'ha);
		print_verdict();
	end

	initial
	begin
		#200us;
		error_cnt++;
		print_verdict();
	end
endmodule
